// ===== core/rus_sequencer.sv
/*
  Remote update sequencer: the user logic that drives the remote upgrade
  circuitry, with an APB slave for its control and status registers.
  Assumes PCLK is MCLK_I and the far end keeps the busy handshake.
*/
// Summary of operation
// R1 - Upgrade clock is source halved, 25 MHz
// R2 - Circuitry boots factory image at word 0x10000
// R3 - Power-up source reads back as zero
// R4 - Factory logic decodes cause of last reload
// R5 - Write upper 12 bits of watchdog value
// R6 - Circuitry appends low fill to watchdog
// R7 - Write upper 22 bits of boot address
// R8 - Circuitry appends two zeros to address
// R9 - Hold reload request at least 250 ns
// R10 - Application images at words 0x70000, 0xD0000
// R11 - Application machine reads current boot address
// R12 - Application machine reads watchdog enable, value
// R13 - All link addresses are word addresses
// R14 - Set boot address before reload request; the application run requests reload without writing it
// R15 - Monitor output shows machine state
// R16 - Busy stays high during parameter access
// R17 - Source one-hot, zero means power-up
// R18 - Launch starts the access sequence
// R19 - Monitor MSB drives reload request
// R20 - Wait busy low before next access
`timescale 1ns/10ps
`default_nettype none

module rus_sequencer (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // State observation
  output logic [7:0] STATE_MON_O,
  // Link to the upgrade circuitry
  rus_link_if.seq LINK
);

  rus_pkg::rus_state_t state_r, state_nxt;
  logic phase_r, phase_nxt;
  logic [7:0] hold_r, hold_nxt;
  logic ru_clk_r;
  logic [7:0] div_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r, rd_mux;
  logic mapped_w, setup_w, wr_acc_w, launch_w;
  logic appmode_r, appsel_r, wden_r, done_r;
  logic [11:0] wdt_hi_r;
  logic [4:0] src_r;
  logic [23:0] boot_rb_r;
  logic rd_wden_r;
  logic [28:0] wdt_rb_r;
  logic rd_r, wr_r;
  logic [1:0] par_r, rsrc_r;
  logic [21:0] din_r;
  logic [23:0] app_waddr;
  logic [4:0] cause_w;

  // Upgrade clock divider; 25 MHz stays under the 40 MHz ceiling
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      div_r <= 8'h00;
      ru_clk_r <= 1'b0;
    end else if (div_r == 8'(rus_pkg::RU_HALF_CYC - 1)) begin
      div_r <= 8'h00;
      ru_clk_r <= ~ru_clk_r; // R1
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // APB decode
  assign setup_w = PSEL_I & ~PENABLE_I;
  assign wr_acc_w = PSEL_I & PENABLE_I & PWRITE_I & pready_r & ~pslverr_r;
  assign launch_w = wr_acc_w && (PADDR_I == rus_pkg::REG_CTRL) && PWDATA_I[rus_pkg::CTRL_LAUNCH];
  assign mapped_w = (PADDR_I == rus_pkg::REG_CTRL) || (PADDR_I == rus_pkg::REG_STATUS) ||
                    (PADDR_I == rus_pkg::REG_BOOT) || (PADDR_I == rus_pkg::REG_WDOG);

  // Cause flags from the past source: watchdog, status pin, CRC, external, first entry
  assign cause_w = {src_r == rus_pkg::SRC_POWERUP, src_r == rus_pkg::SRC_EXT,
                    src_r == rus_pkg::SRC_CRC, src_r == rus_pkg::SRC_STATUS,
                    src_r == rus_pkg::SRC_WDOG}; // R4

  // Read data mux
  always_comb begin
    rd_mux = 32'h00000000;
    case (PADDR_I)
      rus_pkg::REG_CTRL: begin
        rd_mux[rus_pkg::CTRL_APPMODE] = appmode_r;
        rd_mux[rus_pkg::CTRL_APPSEL] = appsel_r;
        rd_mux[rus_pkg::CTRL_WDEN] = wden_r;
        rd_mux[rus_pkg::CTRL_WDT_LSB +: 12] = wdt_hi_r;
      end
      rus_pkg::REG_STATUS: begin
        rd_mux[7:0] = state_r;
        rd_mux[rus_pkg::STAT_BUSY] = LINK.busy;
        rd_mux[rus_pkg::STAT_DONE] = done_r;
        rd_mux[rus_pkg::STAT_SRC_LSB +: 5] = src_r;
        rd_mux[rus_pkg::STAT_CAUSE_LSB +: 5] = cause_w;
      end
      rus_pkg::REG_BOOT: rd_mux[23:0] = boot_rb_r;
      rus_pkg::REG_WDOG: begin
        rd_mux[28:0] = wdt_rb_r;
        rd_mux[rus_pkg::WDOG_EN_BIT] = rd_wden_r;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  // APB answer: one wait-free access phase, error on unmapped addresses
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= setup_w;
      pslverr_r <= setup_w & ~mapped_w;
      prdata_r <= (setup_w && !PWRITE_I) ? rd_mux : 32'h00000000;
    end
  end

  // Control register
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      appmode_r <= 1'b0;
      appsel_r <= 1'b0;
      wden_r <= 1'b0;
      wdt_hi_r <= 12'h000;
    end else if (wr_acc_w && PADDR_I == rus_pkg::REG_CTRL) begin
      appmode_r <= PWDATA_I[rus_pkg::CTRL_APPMODE];
      appsel_r <= PWDATA_I[rus_pkg::CTRL_APPSEL];
      wden_r <= PWDATA_I[rus_pkg::CTRL_WDEN];
      wdt_hi_r <= PWDATA_I[rus_pkg::CTRL_WDT_LSB +: 12];
    end
  end

  // Done flag: set at the end of the reload request, cleared by a launch;
  // a launch is only taken in idle, so set and clear never meet
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      done_r <= 1'b0;
    end else if (state_r == rus_pkg::ST_RECONF && state_nxt == rus_pkg::ST_IDLE) begin
      done_r <= 1'b1;
    end else if (launch_w && state_r == rus_pkg::ST_IDLE) begin
      done_r <= 1'b0;
    end
  end

  // Next machine state; each access runs request, then wait for busy to fall
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    hold_nxt = 8'h00;
    case (state_r)
      rus_pkg::ST_IDLE: begin
        if (launch_w && !LINK.busy) begin // R18 R20
          // Mode comes from the launching write; the control register lags it by one edge
          state_nxt = PWDATA_I[rus_pkg::CTRL_APPMODE] ? rus_pkg::ST_A_RD_BOOT : rus_pkg::ST_F_RD_SRC;
        end
      end
      rus_pkg::ST_F_RD_SRC, rus_pkg::ST_F_WR_WDT, rus_pkg::ST_F_WR_WDEN,
      rus_pkg::ST_F_WR_BOOT, rus_pkg::ST_A_RD_BOOT, rus_pkg::ST_A_RD_WDEN,
      rus_pkg::ST_A_RD_WDT: begin
        if (!phase_r) begin
          if (LINK.busy) begin
            phase_nxt = 1'b1;
          end
        end else if (!LINK.busy) begin // R20
          phase_nxt = 1'b0;
          case (state_r)
            rus_pkg::ST_F_RD_SRC: state_nxt = rus_pkg::ST_F_WR_WDT;
            rus_pkg::ST_F_WR_WDT: state_nxt = rus_pkg::ST_F_WR_WDEN;
            rus_pkg::ST_F_WR_WDEN: state_nxt = rus_pkg::ST_F_WR_BOOT;
            rus_pkg::ST_A_RD_BOOT: state_nxt = rus_pkg::ST_A_RD_WDEN;
            rus_pkg::ST_A_RD_WDEN: state_nxt = rus_pkg::ST_A_RD_WDT;
            default: state_nxt = rus_pkg::ST_RECONF; // R14
          endcase
        end
      end
      rus_pkg::ST_RECONF: begin
        if (hold_r == 8'(rus_pkg::RECONF_CYC - 1)) begin // R9
          state_nxt = rus_pkg::ST_IDLE;
        end else begin
          hold_nxt = hold_r + 8'h01;
        end
      end
      default: state_nxt = rus_pkg::ST_IDLE;
    endcase
  end

  // Machine registers
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_r <= rus_pkg::ST_IDLE;
      phase_r <= 1'b0;
      hold_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      hold_r <= hold_nxt;
    end
  end

  // Word address of the chosen application image
  assign app_waddr = appsel_r ? rus_pkg::APP2_WADDR : rus_pkg::APP1_WADDR; // R10

  // Link request lines, registered from the next state
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      par_r <= rus_pkg::PAR_SRC;
      rsrc_r <= rus_pkg::RSRC_CUR;
      din_r <= 22'h000000;
    end else begin
      rd_r <= !phase_nxt && (state_nxt == rus_pkg::ST_F_RD_SRC || state_nxt == rus_pkg::ST_A_RD_BOOT ||
                             state_nxt == rus_pkg::ST_A_RD_WDEN || state_nxt == rus_pkg::ST_A_RD_WDT);
      wr_r <= !phase_nxt && (state_nxt == rus_pkg::ST_F_WR_WDT || state_nxt == rus_pkg::ST_F_WR_WDEN ||
                             state_nxt == rus_pkg::ST_F_WR_BOOT);
      case (state_nxt)
        rus_pkg::ST_F_RD_SRC: begin
          par_r <= rus_pkg::PAR_SRC;
          rsrc_r <= rus_pkg::RSRC_PAST;
        end
        rus_pkg::ST_F_WR_WDT: begin
          par_r <= rus_pkg::PAR_WDT;
          din_r <= {10'h000, wdt_hi_r}; // R5
        end
        rus_pkg::ST_F_WR_WDEN: begin
          par_r <= rus_pkg::PAR_WDEN;
          din_r <= {21'h000000, wden_r};
        end
        rus_pkg::ST_F_WR_BOOT: begin
          par_r <= rus_pkg::PAR_BOOT;
          din_r <= app_waddr[23:2]; // R7 R13
        end
        rus_pkg::ST_A_RD_BOOT: begin
          par_r <= rus_pkg::PAR_BOOT;
          rsrc_r <= rus_pkg::RSRC_CUR;
        end
        rus_pkg::ST_A_RD_WDEN: begin
          par_r <= rus_pkg::PAR_WDEN;
          rsrc_r <= rus_pkg::RSRC_CUR;
        end
        rus_pkg::ST_A_RD_WDT: begin
          par_r <= rus_pkg::PAR_WDT;
          rsrc_r <= rus_pkg::RSRC_CUR;
        end
        default: ;
      endcase
    end
  end

  // Read-back capture when busy falls on a read
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      src_r <= rus_pkg::SRC_POWERUP;
      boot_rb_r <= 24'h000000;
      rd_wden_r <= 1'b0;
      wdt_rb_r <= 29'h00000000;
    end else if (phase_r && !LINK.busy) begin
      case (state_r)
        rus_pkg::ST_F_RD_SRC: src_r <= LINK.data_out[4:0]; // R4
        rus_pkg::ST_A_RD_BOOT: boot_rb_r <= LINK.data_out[23:0]; // R11
        rus_pkg::ST_A_RD_WDEN: rd_wden_r <= LINK.data_out[0]; // R12
        rus_pkg::ST_A_RD_WDT: wdt_rb_r <= LINK.data_out; // R12
        default: ;
      endcase
    end
  end

  // Outputs
  assign PRDATA_O = prdata_r;
  assign PREADY_O = pready_r;
  assign PSLVERR_O = pslverr_r;
  assign STATE_MON_O = state_r; // R15
  assign LINK.reconfig = state_r[7]; // R19
  assign LINK.ru_clk = ru_clk_r;
  assign LINK.read_param = rd_r;
  assign LINK.write_param = wr_r;
  assign LINK.param = par_r;
  assign LINK.read_source = rsrc_r;
  assign LINK.data_in = din_r;

endmodule // rus_sequencer

`default_nettype wire

// ===== core/rus_pkg.sv
/*
  Shared constants for the remote update sequencer and the remote upgrade
  circuitry end: timing, parameter codes, boot addresses, register map.
  Assumes a single 100 MHz system clock on both ends.
*/
package rus_pkg;

  // Clock figures, in MHz
  localparam int MCLK_MHZ = 100;
  localparam int SRC_MHZ = 50;
  localparam int RU_MHZ = SRC_MHZ / 2;
  localparam int RU_MAX_MHZ = 40;
  // System cycles per half period of the upgrade clock, then its period in ns
  localparam int RU_HALF_CYC = MCLK_MHZ / (2 * RU_MHZ);
  localparam int RU_PERIOD_NS = 1000 / RU_MHZ;

  // Least reload request width, rounded up to whole system cycles
  localparam int RECONF_NS = 250;
  localparam int RECONF_CYC = (RECONF_NS * MCLK_MHZ + 999) / 1000;
  // Width the circuitry insists on, in upgrade clock edges, rounded down
  localparam int RECONF_EDGES = RECONF_NS / RU_PERIOD_NS;
  // Upgrade clock edges a parameter access keeps busy high
  localparam int BUSY_EDGES = 2;

  // Parameter selector codes
  localparam logic [1:0] PAR_SRC = 2'h0;
  localparam logic [1:0] PAR_WDEN = 2'h1;
  localparam logic [1:0] PAR_WDT = 2'h2;
  localparam logic [1:0] PAR_BOOT = 2'h3;
  // Read source codes
  localparam logic [1:0] RSRC_CUR = 2'h0;
  localparam logic [1:0] RSRC_PAST = 2'h1;
  localparam logic [1:0] RSRC_INPUT = 2'h2;

  // Reconfiguration source, one-hot; zero means power-up
  localparam logic [4:0] SRC_POWERUP = 5'h00;
  localparam logic [4:0] SRC_CORE = 5'h01;
  localparam logic [4:0] SRC_WDOG = 5'h02;
  localparam logic [4:0] SRC_STATUS = 5'h04;
  localparam logic [4:0] SRC_CRC = 5'h08;
  localparam logic [4:0] SRC_EXT = 5'h10;

  // Word addresses of the images
  localparam logic [23:0] FACTORY_WADDR = 24'h010000;
  localparam logic [23:0] APP1_WADDR = 24'h070000;
  localparam logic [23:0] APP2_WADDR = 24'h0d0000;
  // Fixed low bits the circuitry appends
  localparam logic [16:0] WDT_LOW_FILL = 17'h00008;
  localparam logic [1:0] BOOT_LOW_FILL = 2'h0;

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BOOT = 8'h08;
  localparam logic [7:0] REG_WDOG = 8'h0c;
  // Control fields
  localparam int CTRL_LAUNCH = 0;
  localparam int CTRL_APPMODE = 1;
  localparam int CTRL_APPSEL = 2;
  localparam int CTRL_WDEN = 3;
  localparam int CTRL_WDT_LSB = 16;
  // Status fields, then the enable bit of the watchdog register
  localparam int STAT_BUSY = 8;
  localparam int STAT_DONE = 9;
  localparam int STAT_SRC_LSB = 10;
  localparam int STAT_CAUSE_LSB = 15;
  localparam int WDOG_EN_BIT = 31;

  // Sequencer states; bit 7 is the reload request
  typedef enum logic [7:0] {
    ST_IDLE = 8'h00,
    ST_F_RD_SRC = 8'h01,
    ST_F_WR_WDT = 8'h02,
    ST_F_WR_WDEN = 8'h03,
    ST_F_WR_BOOT = 8'h04,
    ST_A_RD_BOOT = 8'h11,
    ST_A_RD_WDEN = 8'h12,
    ST_A_RD_WDT = 8'h13,
    ST_RECONF = 8'h80
  } rus_state_t;

endpackage

// ===== core/rus_link_if.sv
/*
  Parameter port between the sequencer and the remote upgrade circuitry.
  Assumes both ends run on the same system clock; ru_clk is a divided clock
  that the circuitry end samples as a pin.
*/
`timescale 1ns/10ps
`default_nettype none

interface rus_link_if;
  logic ru_clk;
  logic reconfig;
  logic read_param;
  logic write_param;
  logic [1:0] param;
  logic [1:0] read_source;
  logic [21:0] data_in;
  logic [28:0] data_out;
  logic busy;

  // Control logic end
  modport seq (
    output ru_clk, reconfig, read_param, write_param, param, read_source, data_in,
    input data_out, busy
  );
  // Upgrade circuitry end
  modport core (
    input ru_clk, reconfig, read_param, write_param, param, read_source, data_in,
    output data_out, busy
  );
endinterface

`default_nettype wire

// ===== core/rus_upgrade_core.sv
/*
  Remote upgrade circuitry end: parameter store, busy handshake, image
  reload on request and on error events.
  Assumes ru_clk from the sequencer and event inputs from pins.
*/
`timescale 1ns/10ps
`default_nettype none

module rus_upgrade_core (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_I,
  // Error events: watchdog, status pin, CRC, external restart
  input wire logic [3:0] EVENT_I,
  // Image state
  output logic [23:0] BOOT_ADDR_O,
  output logic RELOAD_O,
  // Link to the sequencer
  rus_link_if.core LINK
);

  logic ck1_r, ck2_r, ck3_r, edge_w;
  logic [3:0] ev1_r, ev2_r, ev3_r, ev_rise_w;
  logic busy_r, op_wr_r, op_end_w;
  logic [1:0] op_par_r, op_src_r;
  logic [21:0] op_din_r;
  logic [7:0] cnt_r, rq_cnt_r;
  logic [28:0] dout_r, rd_val;
  logic [23:0] cur_boot_r;
  logic cur_wden_r, in_wden_r, reload_w, reload_r;
  logic [28:0] cur_wdt_r;
  logic [4:0] past_src_r;
  logic [21:0] in_boot_r;
  logic [11:0] in_wdt_r;

  // Pin synchronisers; the second and third stages are read by the edge detectors
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      {ck1_r, ck2_r, ck3_r} <= 3'h0;
      ev1_r <= 4'h0;
      ev2_r <= 4'h0;
      ev3_r <= 4'h0;
    end else begin
      ck1_r <= LINK.ru_clk;
      ck2_r <= ck1_r;
      ck3_r <= ck2_r;
      ev1_r <= EVENT_I;
      ev2_r <= ev1_r;
      ev3_r <= ev2_r;
    end
  end
  assign edge_w = ck2_r & ~ck3_r;
  assign ev_rise_w = ev2_r & ~ev3_r;
  assign op_end_w = edge_w && busy_r && cnt_r == 8'(rus_pkg::BUSY_EDGES - 1);

  // Read value; addresses are words with the fixed low bits appended
  always_comb begin
    rd_val = 29'h00000000;
    case (op_par_r)
      rus_pkg::PAR_SRC: rd_val[4:0] = (op_src_r == rus_pkg::RSRC_PAST) ? past_src_r : rus_pkg::SRC_POWERUP; // R3 R17
      rus_pkg::PAR_WDEN: rd_val[0] = (op_src_r == rus_pkg::RSRC_INPUT) ? in_wden_r : cur_wden_r;
      rus_pkg::PAR_WDT: rd_val = (op_src_r == rus_pkg::RSRC_INPUT) ? {in_wdt_r, rus_pkg::WDT_LOW_FILL} : cur_wdt_r;
      rus_pkg::PAR_BOOT: rd_val[23:0] = (op_src_r == rus_pkg::RSRC_INPUT) ?
                                        {in_boot_r, rus_pkg::BOOT_LOW_FILL} : cur_boot_r; // R13
      default: rd_val = 29'h00000000;
    endcase
  end

  // Access handshake: busy rises on an accepted request, falls after the access
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      op_wr_r <= 1'b0;
      op_par_r <= rus_pkg::PAR_SRC;
      op_src_r <= rus_pkg::RSRC_CUR;
      op_din_r <= 22'h000000;
      dout_r <= 29'h00000000;
    end else if (edge_w && !busy_r && (LINK.read_param || LINK.write_param)) begin
      busy_r <= 1'b1; // R16
      cnt_r <= 8'h00;
      op_wr_r <= LINK.write_param;
      op_par_r <= LINK.param;
      op_src_r <= LINK.read_source;
      op_din_r <= LINK.data_in;
    end else if (op_end_w) begin
      busy_r <= 1'b0; // R16
      if (!op_wr_r) begin
        dout_r <= rd_val;
      end
    end else if (edge_w && busy_r) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // Written input parameters
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      in_boot_r <= 22'h000000;
      in_wdt_r <= 12'h000;
      in_wden_r <= 1'b0;
    end else if (op_end_w && op_wr_r) begin
      case (op_par_r)
        rus_pkg::PAR_WDT: in_wdt_r <= op_din_r[11:0];
        rus_pkg::PAR_WDEN: in_wden_r <= op_din_r[0];
        rus_pkg::PAR_BOOT: in_boot_r <= op_din_r;
        default: ;
      endcase
    end
  end

  // Reload request width, counted in upgrade clock edges
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rq_cnt_r <= 8'h00;
    end else if (!LINK.reconfig) begin
      rq_cnt_r <= 8'h00;
    end else if (edge_w && rq_cnt_r != 8'hff) begin
      rq_cnt_r <= rq_cnt_r + 8'h01;
    end
  end
  // A short request is ignored rather than treated as a glitchy reload
  assign reload_w = !LINK.reconfig && rq_cnt_r >= 8'(rus_pkg::RECONF_EDGES);

  // Running image: factory on power-up and on any error not met by a reload in the same cycle, else the written one
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cur_boot_r <= rus_pkg::FACTORY_WADDR; // R2
      past_src_r <= rus_pkg::SRC_POWERUP; // R3
      cur_wden_r <= 1'b0;
      cur_wdt_r <= 29'h00000000;
      reload_r <= 1'b0;
    end else begin
      reload_r <= reload_w;
      if (reload_w) begin
        past_src_r <= rus_pkg::SRC_CORE; // R17
        cur_boot_r <= {in_boot_r, rus_pkg::BOOT_LOW_FILL}; // R8
        cur_wden_r <= in_wden_r;
        cur_wdt_r <= {in_wdt_r, rus_pkg::WDT_LOW_FILL}; // R6
      end else if (ev_rise_w != 4'h0 && cur_boot_r != rus_pkg::FACTORY_WADDR) begin
        cur_boot_r <= rus_pkg::FACTORY_WADDR; // R2
        cur_wden_r <= 1'b0;
        if (ev_rise_w[0]) begin
          past_src_r <= rus_pkg::SRC_WDOG; // R17
        end else if (ev_rise_w[1]) begin
          past_src_r <= rus_pkg::SRC_STATUS;
        end else if (ev_rise_w[2]) begin
          past_src_r <= rus_pkg::SRC_CRC;
        end else begin
          past_src_r <= rus_pkg::SRC_EXT;
        end
      end
    end
  end

  // Outputs
  assign LINK.busy = busy_r;
  assign LINK.data_out = dout_r;
  assign BOOT_ADDR_O = cur_boot_r;
  assign RELOAD_O = reload_r;

endmodule // rus_upgrade_core

`default_nettype wire

// ===== testbench/rus_link_monitor.sv
/*
  Assertions on the parameter link between the sequencer and the upgrade end.
  Assumes one system clock and an active-high asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none

module rus_link_monitor (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_I,
  // Link signals
  input wire logic ru_clk,
  input wire logic reconfig,
  input wire logic read_param,
  input wire logic write_param,
  input wire logic [1:0] param,
  input wire logic [1:0] read_source,
  input wire logic [21:0] data_in,
  input wire logic [28:0] data_out,
  input wire logic busy
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  // A new parameter request and one busy episode
  sequence s_req;
    $rose(read_param || write_param);
  endsequence
  sequence s_busy_cycle;
    busy[*4] ##[1:8] !busy;
  endsequence

  chk_ruclk_half: assert property ($changed(ru_clk) |=> $stable(ru_clk) ##1 $changed(ru_clk))
    else $error("upgrade clock not a halved square wave");
  chk_reconf_width: assert property ($rose(reconfig) |-> reconfig[*8] ##17 reconfig)
    else $error("reload request shorter than 250 ns");
  chk_reconf_quiet: assert property ($rose(reconfig) |-> !busy && !read_param && !write_param)
    else $error("reload request while link active");
  chk_req_idle: assert property (s_req |-> !busy)
    else $error("request issued while busy");
  chk_req_held: assert property ((read_param || write_param) && !busy |=> read_param || write_param)
    else $error("request dropped before busy");
  chk_busy_answer: assert property (s_req |-> ##[1:4] busy)
    else $error("busy did not answer request");
  chk_busy_len: assert property ($rose(busy) |-> s_busy_cycle)
    else $error("busy episode wrong length");
  chk_one_req: assert property (!(read_param && write_param))
    else $error("read and write requested together");
  chk_boot_word: assert property (write_param && param == rus_pkg::PAR_BOOT |->
    data_in == rus_pkg::APP1_WADDR[23:2] || data_in == rus_pkg::APP2_WADDR[23:2])
    else $error("boot write not an image word address");
  chk_src_past: assert property (read_param && param == rus_pkg::PAR_SRC |-> read_source == rus_pkg::RSRC_PAST)
    else $error("source read not from past status");
endmodule // rus_link_monitor

`default_nettype wire

// ===== testbench/remote_update_sequencer_tb.sv
/*
  Testbench: sequencer and upgrade end joined by the link, driven over APB.
  Assumes the one-cycle APB answer and the register map of the hand-over.
*/
`timescale 1ns/10ps
`default_nettype none

module remote_update_sequencer_tb;
  localparam logic [11:0] WDT = 12'ha5c;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, reload, e;
  logic [7:0] state_mon;
  logic [3:0] event_pins = 4'h0;
  logic [23:0] boot;
  int fails = 0, n_compared = 0, n_reload = 0, n_exp = 0;

  rus_link_if link ();
  rus_sequencer i_rus_sequencer (.MCLK_I(mclk), .RESET_I(reset), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .STATE_MON_O(state_mon), .LINK(link));
  rus_upgrade_core i_rus_upgrade_core (.MCLK_I(mclk), .RESET_I(reset), .EVENT_I(event_pins),
    .BOOT_ADDR_O(boot), .RELOAD_O(reload), .LINK(link));
  rus_link_monitor i_rus_link_monitor (.MCLK_I(mclk), .RESET_I(reset), .ru_clk(link.ru_clk),
    .reconfig(link.reconfig), .read_param(link.read_param), .write_param(link.write_param),
    .param(link.param), .read_source(link.read_source), .data_in(link.data_in),
    .data_out(link.data_out), .busy(link.busy));

  // 100 MHz system clock
  initial begin
    forever #5 mclk = ~mclk;
  end

  // Count honoured reloads; the edge sees the pre-update pulse
  always @(posedge mclk) begin
    if (reload === 1'b1) n_reload++;
  end

  // Reload request mirrors the monitor MSB, sampled mid-cycle where settled
  always @(negedge mclk) begin
    if (!reset) chk("reload msb", {31'h0, state_mon[7]}, {31'h0, link.reconfig});
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; the trailing edge keeps psel from being set twice in a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // Start a sequence and poll until its reload request has ended
  task launch(input logic m, input logic s);
    n_exp++;
    apb(1'b1, rus_pkg::REG_CTRL, {4'h0, WDT, 12'h000, 1'b1, s, m, 1'b1}, r, e);
    repeat (300) begin
      apb(1'b0, rus_pkg::REG_STATUS, 32'h0, r, e);
      if (r[rus_pkg::STAT_DONE] === 1'b1) break;
    end
    chk("done", 32'h1, r[rus_pkg::STAT_DONE]);
    repeat (4) @(posedge mclk);
    chk("reloads", n_exp, n_reload);
    chk("state", rus_pkg::ST_IDLE, state_mon);
  endtask

  task t_power_up;
    launch(1'b0, 1'b1);
    apb(1'b0, rus_pkg::REG_STATUS, 32'h0, r, e);
    chk("source", 32'h0, r[14:10]);
    chk("cause", 32'h10, r[19:15]);
    chk("boot", rus_pkg::APP2_WADDR, boot);
  endtask

  task t_app_read;
    launch(1'b1, 1'b0);
    apb(1'b0, rus_pkg::REG_BOOT, 32'h0, r, e);
    chk("boot read", rus_pkg::APP2_WADDR, r[23:0]);
    apb(1'b0, rus_pkg::REG_WDOG, 32'h0, r, e);
    chk("wdog read", {1'b1, 2'b00, WDT, rus_pkg::WDT_LOW_FILL}, r);
  endtask

  task t_unmapped;
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("slverr", 32'h1, e);
    chk("unmapped data", 32'h0, r);
  endtask

  // Each error pin sends the image home, then the factory run decodes it
  task t_events;
    launch(1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      event_pins <= 4'h1 << i;
      repeat (4) @(posedge mclk);
      event_pins <= 4'h0;
      repeat (60) begin
        @(posedge mclk);
        if (boot === rus_pkg::FACTORY_WADDR) break;
      end
      chk("factory", rus_pkg::FACTORY_WADDR, boot);
      launch(1'b0, i[0]);
      apb(1'b0, rus_pkg::REG_STATUS, 32'h0, r, e);
      chk("source", 5'h02 << i, r[14:10]);
      chk("cause", 5'h01 << i, r[19:15]);
      chk("boot", i[0] ? rus_pkg::APP2_WADDR : rus_pkg::APP1_WADDR, boot);
    end
  endtask

  task summarize;
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_power_up();
    t_app_read();
    t_unmapped();
    t_events();
    summarize();
  end

  // Seven launches need under a thousand cycles; allow well beyond that
  initial begin
    #200000;
    fails++;
    summarize();
  end
endmodule // remote_update_sequencer_tb

`default_nettype wire
